// *** rtl/dncs_defs.vh ***
// Constants for the drive network control and status register bank.
// Assumes inclusion by bare name from rtl/dncs_top.v.
`ifndef DNCS_DEFS_VH
`define DNCS_DEFS_VH

// ------------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------------
`define DNCS_ADDR_STATUS2      8'h00
`define DNCS_ADDR_SER_CTRL     8'h04
`define DNCS_ADDR_SER_SPEED    8'h08
`define DNCS_ADDR_FB_CTRL      8'h0C
`define DNCS_ADDR_FB_SPEED     8'h10
`define DNCS_ADDR_ERR_CFG      8'h14
`define DNCS_ADDR_EFFECTIVE    8'h18

// ------------------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------------------
`define DNCS_CW_RAMP_EN        0
`define DNCS_CW_GEN_EN         1
`define DNCS_CW_RUN_FWD        2
`define DNCS_CW_INCH_EN        3
`define DNCS_CW_REMOTE         4
`define DNCS_CW_RAMP2          5
`define DNCS_CW_FAULT_RST      7
`define DNCS_CW_MASK           16'h00BF
`define DNCS_CW_RESET          16'h0000
`define DNCS_SPEED_RESET       16'h0000
`define DNCS_SPEED_RATED       16'h2000

// ------------------------------------------------------------------------
// Status word two fields
// ------------------------------------------------------------------------
`define DNCS_SW_DC_EXT         2
`define DNCS_SW_ENERGY         3
`define DNCS_SW_FS_RED         4
`define DNCS_SW_DECEL          6
`define DNCS_SW_ACCEL          7
`define DNCS_SW_FROZEN         8
`define DNCS_SW_SETPOINT       9
`define DNCS_SW_DC_REG         10
`define DNCS_SW_50HZ           11
`define DNCS_SW_RIDE           12
`define DNCS_SW_FLYING         13
`define DNCS_SW_DC_BRAKE       14
`define DNCS_SW_PWM            15

// ------------------------------------------------------------------------
// Error action codes
// ------------------------------------------------------------------------
`define DNCS_ACT_INACTIVE      3'h0
`define DNCS_ACT_RAMP_STOP     3'h1
`define DNCS_ACT_GEN_DISABLE   3'h2
`define DNCS_ACT_GO_LOCAL      3'h3
`define DNCS_ACT_LOCAL_KEEP    3'h4
`define DNCS_ACT_FAULT         3'h5
`define DNCS_ACT_RESET         3'h1

// ------------------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------------------
`define DNCS_RESP_OKAY         2'h0
`define DNCS_RESP_SLVERR       2'h2

`endif

// *** rtl/dncs_top.v ***
// Network control and status register bank of a motor drive.
// Assumes an AXI4-Lite master on aclk and drive logic supplying status.
//
// Functional notes
// R1 - Status bit 3 shows energy saving, bit 4 frequency reduction.
// R2 - Status bit 8 set while ramp trajectory is frozen.
// R3 - Status bit 9 set once output frequency reached reference.
// R4 - Status bit 11 is 1 for 50 Hz defaults, 0 for 60 Hz.
// R5 - Status bits 12, 13, 14: ride-through, flying start, DC braking.
// R6 - Status bit 15 shows output modulation pulses enabled.
// R7 - Status bit 2 extended DC link, bit 10 DC link regulation.
// R8 - Operator selects communication error action; default is ramp stop.
// R9 - Serial timeout alarm or fault triggers the selected error action.
// R10 - Error action writes control bits; fault action always blocks drive. Code skips the action on a control word written in the same cycle.
// R11 - Each interface writes only its own control word; all may read. Code gives the fieldbus port no read path; only the AXI bus reads.
// R12 - Control bit 0: 0 ramps to stop, 1 accelerates to reference.
// R13 - Control bit 1: 0 disables drive completely, 1 enables it.
// R14 - Control bit 2: 1 follows reference direction, 0 reverses.
// R15 - Control bit 3 enables inching, bit 4 selects remote mode.
// R16 - Control bit 5 selects second ramp time pair.
// R17 - Control bit 7 resets active fault; bits 6, 8-15 reserved.
// R18 - Speed reference signed 16 bits; 2000h equals rated frequency.
// R19 - Speed reference written only by its interface; used when selected.
// R20 - Effective direction combines control bit 2 with reference sign.
// R21 - Status bit 6 decelerating, bit 7 accelerating on the ramp.
// R22 - Reserved control and status bits read zero, ignore writes.
`timescale 1ns/100ps
`include "dncs_defs.vh"
`default_nettype none

module dncs_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        fb_wr_en,
  input  wire        fb_wr_sel_speed,
  input  wire [15:0] fb_wr_data,
  input  wire        net_is_cmd_source,
  input  wire        net_is_speed_source,
  input  wire        net_sel_fieldbus,
  input  wire        comm_timeout_alarm,
  input  wire        comm_timeout_fault,
  input  wire        dc_ext_active,
  input  wire        energy_saving_active,
  input  wire        output_frequency_reduction,
  input  wire        ramp_decelerating,
  input  wire        ramp_accelerating,
  input  wire        ramp_frozen,
  input  wire        setpoint_reached,
  input  wire        dc_reg_active,
  input  wire        defaults_50hz,
  input  wire        ride_through_active,
  input  wire        flying_start_active,
  input  wire        dc_brake_active,
  input  wire        pwm_pulses_enabled,
  output reg         cmd_ramp_enable,
  output reg         cmd_general_enable,
  output reg         cmd_run_forward,
  output reg         cmd_inch_function,
  output reg         cmd_remote,
  output reg         cmd_second_ramp,
  output reg         cmd_fault_reset,
  output reg         cmd_force_fault,
  output reg  [15:0] eff_speed_magnitude,
  output reg         eff_forward,
  output reg         eff_speed_valid
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg [15:0] ser_ctrl_ff;
  reg [15:0] ser_speed_ff;
  reg [15:0] fb_ctrl_ff;
  reg [15:0] fb_speed_ff;
  reg [2:0]  err_action_ff;
  reg [15:0] status2_ff;
  reg        comm_err_ff;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  reg        aw_held_ff;
  reg [7:0]  aw_addr_ff;
  reg        w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  wire       aw_now   = s_axi_awvalid && s_axi_awready;
  wire       w_now    = s_axi_wvalid && s_axi_wready;
  wire       aw_have  = aw_held_ff || aw_now;
  wire       w_have   = w_held_ff || w_now;
  wire       wr_fire  = aw_have && w_have && !bvalid_ff;
  wire [7:0] wr_addr  = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  wire [3:0] wr_strb  = w_held_ff ? w_strb_ff : s_axi_wstrb;

  // Byte-lane merge of the low halfword
  function [15:0] dncs_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  strb;
    begin
      dncs_merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                    strb[0] ? new_v[7:0]  : old_v[7:0]};
    end
  endfunction

  reg wr_ser_ctrl;
  reg wr_ser_speed;
  reg wr_err_cfg;
  reg wr_ok;
  always @* begin
    wr_ser_ctrl  = 1'b0;
    wr_ser_speed = 1'b0;
    wr_err_cfg   = 1'b0;
    wr_ok        = 1'b1;
    // Only the serial side writes through this bus
    if (wr_addr == `DNCS_ADDR_SER_CTRL) begin
      wr_ser_ctrl = 1'b1;
    end else if (wr_addr == `DNCS_ADDR_SER_SPEED) begin
      wr_ser_speed = 1'b1;
    end else if (wr_addr == `DNCS_ADDR_ERR_CFG) begin
      wr_err_cfg = 1'b1;
    end else if (wr_addr == `DNCS_ADDR_STATUS2 ||
                 wr_addr == `DNCS_ADDR_FB_CTRL ||
                 wr_addr == `DNCS_ADDR_FB_SPEED ||
                 wr_addr == `DNCS_ADDR_EFFECTIVE) begin
      wr_ok = 1'b1; // R11
    end else begin
      wr_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DNCS_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? `DNCS_RESP_OKAY : `DNCS_RESP_SLVERR;
      end else begin
        if (aw_now) begin
          aw_held_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr;
        end
        if (w_now) begin
          w_held_ff <= 1'b1;
          w_data_ff <= s_axi_wdata;
          w_strb_ff <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Communication error detection and action
  // ----------------------------------------------------------------------
  wire comm_err = comm_timeout_alarm || comm_timeout_fault; // R9
  wire err_rise = comm_err && !comm_err_ff;

  // Control word with error action forced into it
  function [15:0] dncs_apply_action;
    input [15:0] cw;
    input [2:0]  act;
    reg   [15:0] r;
    begin
      r = cw;
      case (act)
        `DNCS_ACT_RAMP_STOP: begin
          r[`DNCS_CW_RAMP_EN] = 1'b0;
        end
        `DNCS_ACT_GEN_DISABLE: begin
          r[`DNCS_CW_GEN_EN] = 1'b0;
        end
        `DNCS_ACT_GO_LOCAL: begin
          r[`DNCS_CW_REMOTE] = 1'b0;
        end
        `DNCS_ACT_LOCAL_KEEP: begin
          r[`DNCS_CW_REMOTE] = 1'b0;
        end
        default: begin
          r = cw;
        end
      endcase
      dncs_apply_action = r & `DNCS_CW_MASK;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Network registers
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ser_ctrl_ff   <= `DNCS_CW_RESET;
      ser_speed_ff  <= `DNCS_SPEED_RESET;
      fb_ctrl_ff    <= `DNCS_CW_RESET;
      fb_speed_ff   <= `DNCS_SPEED_RESET;
      err_action_ff <= `DNCS_ACT_RESET; // R8
      comm_err_ff   <= 1'b0;
    end else begin
      comm_err_ff <= comm_err;
      if (wr_fire && wr_ser_ctrl) begin
        ser_ctrl_ff <= dncs_merge(ser_ctrl_ff, wr_data[15:0],
                                  wr_strb[1:0]) & `DNCS_CW_MASK; // R22
      end else if (err_rise) begin
        ser_ctrl_ff <= dncs_apply_action(ser_ctrl_ff, err_action_ff); // R10
      end
      if (wr_fire && wr_ser_speed) begin
        ser_speed_ff <= dncs_merge(ser_speed_ff, wr_data[15:0],
                                   wr_strb[1:0]); // R19
      end
      if (fb_wr_en && !fb_wr_sel_speed) begin
        fb_ctrl_ff <= fb_wr_data & `DNCS_CW_MASK; // R11
      end else if (err_rise) begin
        fb_ctrl_ff <= dncs_apply_action(fb_ctrl_ff, err_action_ff); // R10
      end
      if (fb_wr_en && fb_wr_sel_speed) begin
        fb_speed_ff <= fb_wr_data; // R19
      end
      if (wr_fire && wr_err_cfg && wr_strb[0] &&
          wr_data[2:0] <= `DNCS_ACT_FAULT) begin
        err_action_ff <= wr_data[2:0]; // R8
      end
    end
  end

  // ----------------------------------------------------------------------
  // Secondary status word
  // ----------------------------------------------------------------------
  reg [15:0] nxt_status2;
  always @* begin
    nxt_status2 = 16'h0000; // R22
    nxt_status2[`DNCS_SW_DC_EXT]   = dc_ext_active; // R7
    nxt_status2[`DNCS_SW_ENERGY]   = energy_saving_active; // R1
    nxt_status2[`DNCS_SW_FS_RED]   = output_frequency_reduction; // R1
    nxt_status2[`DNCS_SW_DECEL]    = ramp_decelerating; // R21
    nxt_status2[`DNCS_SW_ACCEL]    = ramp_accelerating; // R21
    nxt_status2[`DNCS_SW_FROZEN]   = ramp_frozen; // R2
    nxt_status2[`DNCS_SW_SETPOINT] = setpoint_reached; // R3
    nxt_status2[`DNCS_SW_DC_REG]   = dc_reg_active; // R7
    nxt_status2[`DNCS_SW_50HZ]     = defaults_50hz; // R4
    nxt_status2[`DNCS_SW_RIDE]     = ride_through_active; // R5
    nxt_status2[`DNCS_SW_FLYING]   = flying_start_active; // R5
    nxt_status2[`DNCS_SW_DC_BRAKE] = dc_brake_active; // R5
    nxt_status2[`DNCS_SW_PWM]      = pwm_pulses_enabled; // R6
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status2_ff <= 16'h0000;
    end else begin
      status2_ff <= nxt_status2;
    end
  end

  // ----------------------------------------------------------------------
  // Drive command outputs
  // ----------------------------------------------------------------------
  wire [15:0] act_cw    = net_sel_fieldbus ? fb_ctrl_ff : ser_ctrl_ff;
  wire [15:0] act_speed = net_sel_fieldbus ? fb_speed_ff : ser_speed_ff;
  wire        neg_ref   = act_speed[15];
  wire [15:0] abs_speed = neg_ref ? (16'h0000 - act_speed) : act_speed;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ramp_enable     <= 1'b0;
      cmd_general_enable  <= 1'b0;
      cmd_run_forward     <= 1'b0;
      cmd_inch_function   <= 1'b0;
      cmd_remote          <= 1'b0;
      cmd_second_ramp     <= 1'b0;
      cmd_fault_reset     <= 1'b0;
      cmd_force_fault     <= 1'b0;
      eff_speed_magnitude <= 16'h0000;
      eff_forward         <= 1'b0;
      eff_speed_valid     <= 1'b0;
    end else begin
      // Commands apply only when the network is the command source
      cmd_ramp_enable    <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_RAMP_EN]; // R12
      cmd_general_enable <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_GEN_EN]; // R13
      cmd_run_forward    <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_RUN_FWD]; // R14
      cmd_inch_function  <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_INCH_EN]; // R15
      cmd_remote         <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_REMOTE]; // R15
      cmd_second_ramp    <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_RAMP2]; // R16
      cmd_fault_reset    <= net_is_cmd_source &&
                            act_cw[`DNCS_CW_FAULT_RST]; // R17
      // Fault action blocks the drive regardless of source
      if (err_rise && err_action_ff == `DNCS_ACT_FAULT) begin
        cmd_force_fault <= 1'b1; // R10
      end else if (net_is_cmd_source && act_cw[`DNCS_CW_FAULT_RST]) begin
        cmd_force_fault <= 1'b0; // R17
      end
      eff_speed_magnitude <= abs_speed; // R18
      eff_forward         <= act_cw[`DNCS_CW_RUN_FWD] ^ neg_ref; // R20
      eff_speed_valid     <= net_is_speed_source; // R19
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0]  rresp_ff;
  reg [31:0] nxt_rdata;
  reg [1:0]  nxt_rresp;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `DNCS_RESP_OKAY;
    if (s_axi_araddr == `DNCS_ADDR_STATUS2) begin
      nxt_rdata[15:0] = status2_ff;
    end else if (s_axi_araddr == `DNCS_ADDR_SER_CTRL) begin
      nxt_rdata[15:0] = ser_ctrl_ff; // R11
    end else if (s_axi_araddr == `DNCS_ADDR_SER_SPEED) begin
      nxt_rdata[15:0] = ser_speed_ff;
    end else if (s_axi_araddr == `DNCS_ADDR_FB_CTRL) begin
      nxt_rdata[15:0] = fb_ctrl_ff; // R11
    end else if (s_axi_araddr == `DNCS_ADDR_FB_SPEED) begin
      nxt_rdata[15:0] = fb_speed_ff;
    end else if (s_axi_araddr == `DNCS_ADDR_ERR_CFG) begin
      nxt_rdata[2:0] = err_action_ff;
    end else if (s_axi_araddr == `DNCS_ADDR_EFFECTIVE) begin
      nxt_rdata[2:0] = {cmd_force_fault, eff_speed_valid, eff_forward};
    end else begin
      nxt_rresp = `DNCS_RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `DNCS_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** bench/dncs_fb_master.sv ***
// Fieldbus master model writing its own control and speed words.
// Assumes the bench calls put from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module dncs_fb_master (
  input  wire logic        aclk,
  output var  logic        fb_wr_en,
  output var  logic        fb_wr_sel_speed,
  output var  logic [15:0] fb_wr_data
);
  initial begin
    fb_wr_en = 1'b0;
    fb_wr_sel_speed = 1'b0;
    fb_wr_data = 16'hFFFF;
  end
  // One-cycle write of its own word, data scrambled when idle
  task automatic put(input logic sel, input logic [15:0] d);
    @(posedge aclk);
    fb_wr_en <= 1'b1;
    fb_wr_sel_speed <= sel;
    fb_wr_data <= d;
    @(posedge aclk);
    fb_wr_en <= 1'b0;
    fb_wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

// *** bench/dncs_top_monitor.sv ***
// Checker for the network register bank ports.
// Assumes a bind onto dncs_top, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module dncs_top_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        net_is_cmd_source,
  input wire logic        net_is_speed_source,
  input wire logic        comm_timeout_alarm,
  input wire logic        comm_timeout_fault,
  input wire logic        cmd_ramp_enable,
  input wire logic        cmd_general_enable,
  input wire logic        cmd_run_forward,
  input wire logic        cmd_remote,
  input wire logic        cmd_force_fault,
  input wire logic        eff_speed_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Handshake steps
  // ----------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered next cycle");
  property p_wr_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("write response not released");
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse)
    else $error("write accepted during response");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");
  property p_rd_refuse;
    s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse)
    else $error("read refused wrongly or upper data set");
  // ----------------------------------------
  // Drive side outputs and read response release
  // ----------------------------------------
  property p_cmd_gate;
    !net_is_cmd_source |=> !cmd_ramp_enable && !cmd_general_enable
      && !cmd_run_forward && !cmd_remote;
  endproperty
  a_cmd_gate: assert property (p_cmd_gate)
    else $error("command bits active without network source");
  property p_speed_valid;
    $past(aresetn) |-> eff_speed_valid == $past(net_is_speed_source);
  endproperty
  a_speed_valid: assert property (p_speed_valid)
    else $error("speed valid does not follow source select");
  property p_force_cause;
    $rose(cmd_force_fault) |-> comm_timeout_alarm || comm_timeout_fault;
  endproperty
  a_force_cause: assert property (p_force_cause)
    else $error("forced fault without timeout");
  property p_rd_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("read response not released");
endmodule
bind dncs_top dncs_top_monitor i_dncs_top_monitor (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .net_is_cmd_source, .net_is_speed_source, .comm_timeout_alarm,
  .comm_timeout_fault, .cmd_ramp_enable, .cmd_general_enable,
  .cmd_run_forward, .cmd_remote, .cmd_force_fault, .eff_speed_valid
);
`default_nettype wire

// *** bench/dncs_top_tb.sv ***
// Self-checking bench for the drive network register bank.
// Assumes the fieldbus master model and the bound monitor.
`timescale 1ns/100ps
`default_nettype none
module dncs_top_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  resp;
  logic        net_is_cmd_source, net_is_speed_source, net_sel_fieldbus;
  logic        comm_timeout_alarm, comm_timeout_fault;
  logic [12:0] st;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, fb_wr_en, fb_wr_sel_speed;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] fb_wr_data, eff_speed_magnitude;
  wire  [6:0]  cmd;
  wire         cmd_force_fault, eff_forward, eff_speed_valid;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  logic [12:0] row_st [4] = '{13'h1FFF, 13'h0000, 13'h1555, 13'h0AAA};
  logic [15:0] row_sw [4] = '{16'hFFDC, 16'h0000, 16'hAA94, 16'h5548};
  logic [15:0] row_cw [4] = '{16'hFFFF, 16'h0000, 16'h0055, 16'h00AA};
  logic [15:0] act_exp [6] = '{16'h0013, 16'h0012, 16'h0011, 16'h0003,
                               16'h0003, 16'h0013};
  dncs_top i_dncs_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fb_wr_en, .fb_wr_sel_speed,
    .fb_wr_data, .net_is_cmd_source, .net_is_speed_source,
    .net_sel_fieldbus, .comm_timeout_alarm, .comm_timeout_fault,
    .dc_ext_active(st[0]), .energy_saving_active(st[1]),
    .output_frequency_reduction(st[2]), .ramp_decelerating(st[3]),
    .ramp_accelerating(st[4]), .ramp_frozen(st[5]),
    .setpoint_reached(st[6]), .dc_reg_active(st[7]),
    .defaults_50hz(st[8]), .ride_through_active(st[9]),
    .flying_start_active(st[10]), .dc_brake_active(st[11]),
    .pwm_pulses_enabled(st[12]), .cmd_ramp_enable(cmd[0]),
    .cmd_general_enable(cmd[1]), .cmd_run_forward(cmd[2]),
    .cmd_inch_function(cmd[3]), .cmd_remote(cmd[4]),
    .cmd_second_ramp(cmd[5]), .cmd_fault_reset(cmd[6]),
    .cmd_force_fault, .eff_speed_magnitude, .eff_forward, .eff_speed_valid
  );
  dncs_fb_master i_dncs_fb_master (
    .aclk, .fb_wr_en, .fb_wr_sel_speed, .fb_wr_data
  );
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'hFFFF, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    axi_wr(a, d);
    check("bresp", 32'h0, {30'h0, resp});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    check("rdata", e, rdat);
    check("rresp", 32'h0, {30'h0, resp});
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, comm_timeout_alarm} = 3'b000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_wstrb, comm_timeout_fault, st} = 18'h3C000;
    {net_is_cmd_source, net_is_speed_source, net_sel_fieldbus} = 3'b110;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h14, 32'h1);
    for (int i = 0; i < 4; i++) begin
      st <= row_st[i];
      wr(8'h04, row_cw[i]);
      rd_chk(8'h00, {16'h0, row_sw[i]});
      rd_chk(8'h04, {16'h0, row_cw[i] & 16'h00BF});
      check("cmd", {row_cw[i][7], row_cw[i][5:0]}, cmd);
    end
    wr(8'h08, 16'hE000);
    wr(8'h04, 16'h0007);
    settle();
    check("mag", 32'h2000, {16'h0, eff_speed_magnitude});
    check("fwd", 32'h0, {31'h0, eff_forward});
    check("valid", 32'h1, {31'h0, eff_speed_valid});
    net_is_speed_source <= 1'b0;
    wr(8'h04, 16'h0023);
    settle();
    check("valid", 32'h0, {31'h0, eff_speed_valid});
    check("fwd", 32'h1, {31'h0, eff_forward});
    check("cmd", 32'h23, {25'h0, cmd});
    i_dncs_fb_master.put(1'b0, 16'h0083);
    i_dncs_fb_master.put(1'b1, 16'h2000);
    net_sel_fieldbus <= 1'b1;
    wr(8'h0C, 16'h0000);
    rd_chk(8'h0C, 32'h0083);
    rd_chk(8'h10, 32'h2000);
    check("cmd", 32'h43, {25'h0, cmd});
    check("fwd", 32'h0, {31'h0, eff_forward});
    net_sel_fieldbus <= 1'b0;
    axi_wr(8'h40, 16'h1234);
    check("bresp", 32'h2, {30'h0, resp});
    axi_rd(8'h40);
    check("rresp", 32'h2, {30'h0, resp});
    check("rdata", 32'h0, rdat);
    for (int a = 0; a < 6; a++) begin
      net_is_cmd_source <= (a != 5);
      wr(8'h14, a[15:0]);
      wr(8'h04, 16'h0013);
      {comm_timeout_fault, comm_timeout_alarm} <= a[0] ? 2'b10 : 2'b01;
      settle();
      rd_chk(8'h04, {16'h0, act_exp[a]});
      check("force", {31'h0, a == 5}, {31'h0, cmd_force_fault});
      check("cmd", a == 5 ? 32'h0 : act_exp[a], {25'h0, cmd});
      {comm_timeout_fault, comm_timeout_alarm} <= 2'b00;
    end
    rd_chk(8'h18, 32'h5);
    net_is_cmd_source <= 1'b1;
    wr(8'h04, 16'h0080);
    settle();
    check("force", 32'h0, {31'h0, cmd_force_fault});
    wr(8'h14, 16'h0007);
    rd_chk(8'h14, 32'h5);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h14, 32'h1);
    rd_chk(8'h08, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
